// >>> rtl/trs_pkg.sv
// package: offsets, field layout, reset values and types of the
// thermal limit and rail status register bank.
// assumes a 32-bit ahb-lite bus, one register per aligned word.
package trs_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_ACQ = 8'h0D;
  localparam logic [7:0] IDX_THR = 8'h0E;
  localparam logic [7:0] IDX_RAIL = 8'h0F;
  localparam logic [7:0] IDX_REV = 8'h10;
  localparam logic [9:0] ADDR_ACQ = {IDX_ACQ, 2'b00};
  localparam logic [9:0] ADDR_THR = {IDX_THR, 2'b00};
  localparam logic [9:0] ADDR_RAIL = {IDX_RAIL, 2'b00};
  localparam logic [9:0] ADDR_REV = {IDX_REV, 2'b00};

  // acquisition control word
  localparam int ACQ_BIT = 7;
  localparam int FIN_BIT = 5;
  localparam logic [7:0] ACQ_RW_MASK = 8'h5F;
  localparam logic [7:0] ACQ_RST = 8'h20;

  // threshold word
  localparam int COLD_MSB = 7;
  localparam int COLD_LSB = 4;
  localparam int HOT_MSB = 3;
  localparam int HOT_LSB = 0;
  localparam logic [7:0] THR_RST = 8'h78;
  localparam logic signed [8:0] COLD_BASE_C = -9'sd7;
  localparam logic signed [8:0] HOT_BASE_C = 9'sd42;

  // rail status bit positions
  localparam int RAIL_BOOST_BIT = 7;
  localparam int RAIL_GH_BIT = 6;
  localparam int RAIL_INV_BIT = 5;
  localparam int RAIL_PLDO_BIT = 4;
  localparam int RAIL_GL_BIT = 3;
  localparam int RAIL_NLDO_BIT = 1;
  localparam logic [7:0] RAIL_RST = 8'h00;

  // revision fields; values are arbitrary
  localparam logic [1:0] MAJOR_REV = 2'h0;
  localparam logic [1:0] MINOR_REV = 2'h1;
  localparam logic [3:0] VERSION = 4'h2;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic positive_boost_good;
    logic gate_high_pump_good;
    logic inverting_converter_good;
    logic positive_ldo_good;
    logic gate_low_pump_good;
    logic negative_ldo_good;
  } trs_rails_t;

  typedef struct packed {
    logic hot;
    logic cold;
  } trs_alarm_t;

  typedef enum logic [1:0] {
    ACQ_IDLE = 2'b00,
    ACQ_START = 2'b01,
    ACQ_WAIT = 2'b11
  } trs_acq_state_t;

endpackage : trs_pkg

// >>> rtl/trs_sync.sv
// two-stage synchroniser for a group of level inputs.
// assumes inputs are asynchronous levels from the analog rails.
`timescale 1ns/1ps
module trs_sync #(
  parameter int WIDTH = 6
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // levels
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;

endmodule : trs_sync

// >>> rtl/trs_alarm_eval.sv
// hot and cold threshold comparison of one finished reading.
// assumes eval_i is a one-cycle pulse with temp_i valid in that cycle.
`timescale 1ns/1ps
module trs_alarm_eval (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // reading and thresholds
  input wire logic eval_i,
  input wire logic signed [7:0] temp_i,
  input wire logic [7:0] thr_i,
  // one-cycle alarm pulses
  output trs_pkg::trs_alarm_t alarm_o
);

  trs_pkg::trs_alarm_t alarm_q;
  trs_pkg::trs_alarm_t alarm_d;
  logic signed [8:0] temp_x;
  logic signed [8:0] cold_lim;
  logic signed [8:0] hot_lim;

  always_comb begin
    temp_x = 9'(temp_i);
    cold_lim = trs_pkg::COLD_BASE_C
      + $signed({5'h00, thr_i[trs_pkg::COLD_MSB:trs_pkg::COLD_LSB]});
    hot_lim = trs_pkg::HOT_BASE_C
      + $signed({5'h00, thr_i[trs_pkg::HOT_MSB:trs_pkg::HOT_LSB]});
    alarm_d.cold = eval_i && (temp_x <= cold_lim);
    alarm_d.hot = eval_i && (temp_x >= hot_lim);
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      alarm_q <= '0;
    end else begin
      alarm_q <= alarm_d;
    end
  end

  assign alarm_o = alarm_q;

endmodule : trs_alarm_eval

// >>> rtl/trs_regs.sv
// thermal alarm thresholds, acquisition control, rail status,
// all-good pin and revision, reached over ahb-lite.
// assumes a converter on core_clk that answers a start pulse with a
// done pulse and a signed reading in whole degrees.
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps

// Overview of operation
// - cold threshold bits 7:4, reset 7h, code 0 is -7 C; alarm at or below.
// - hot threshold bits 3:0, reset 8h, code 0 is 42 C; alarm at or above.
// - all-good pin released only when four gate and ldo rails are good.
// - rail status read-only, one bit per rail, bits 2 and 0 read zero.
// - revision read-only: major 7:6, minor 5:4, version 3:0.
// - writing 1 starts acquisition; bit self-clears and finished flag sets.
module trs_regs (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // rail good levels and open-drain all-good pin
  input wire trs_pkg::trs_rails_t rails_good_i,
  input wire logic all_rails_good_pin_i,
  output logic all_rails_good_pin_o,
  output logic all_rails_good_pin_oe_n_o,
  // temperature converter
  output logic temp_start_o,
  input wire logic temp_done_i,
  input wire logic signed [7:0] temp_value_i,
  // alarms, one-cycle pulses
  output trs_pkg::trs_alarm_t alarm_o
);

  function automatic logic addr_hit(input logic [31:0] a, input logic [9:0] r);
    addr_hit = (a[31:10] == 22'h000000) && (a[9:0] == r);
  endfunction : addr_hit

  // bus state
  logic ap;
  logic wr_pend_q;
  logic wr_pend_d;
  logic [9:0] wa_q;
  logic [9:0] wa_d;
  logic wa_ok_q;
  logic wa_ok_d;
  logic [31:0] hrdata_q;
  logic [31:0] hrdata_d;

  // register state
  logic [7:0] thr_q;
  logic [7:0] thr_d;
  logic [7:0] acq_misc_q;
  logic [7:0] acq_misc_d;
  logic fin_q;
  logic fin_d;
  trs_pkg::trs_acq_state_t st_q;
  trs_pkg::trs_acq_state_t st_d;
  logic pin_rel_q;
  logic pin_rel_d;

  logic wr_acq;
  logic wr_thr;
  logic eval;
  logic all_good;
  trs_pkg::trs_rails_t rails_s;
  logic [7:0] rail_word;
  logic [7:0] acq_word_d;
  logic [7:0] rev_word;

  trs_sync #(
    .WIDTH(6)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(rails_good_i),
    .sync_o(rails_s)
  );

  trs_alarm_eval u_eval (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .eval_i(eval),
    .temp_i(temp_value_i),
    .thr_i(thr_q),
    .alarm_o(alarm_o)
  );

  // bus decode; zero wait states, always okay
  always_comb begin
    ap = hsel_i && hready_i && htrans_i[1];
    wr_pend_d = ap && hwrite_i;
    wa_d = ap ? haddr_i[9:0] : wa_q;
    wa_ok_d = ap && (haddr_i[31:10] == 22'h000000);
    wr_acq = wr_pend_q && wa_ok_q && (wa_q == trs_pkg::ADDR_ACQ);
    wr_thr = wr_pend_q && wa_ok_q && (wa_q == trs_pkg::ADDR_THR);
  end

  // acquisition sequence and register next values
  always_comb begin
    st_d = st_q;
    fin_d = fin_q;
    thr_d = thr_q;
    acq_misc_d = acq_misc_q;
    eval = 1'b0;
    if (wr_thr) begin
      thr_d = hwdata_i[7:0];
    end
    if (wr_acq) begin
      acq_misc_d = hwdata_i[7:0] & trs_pkg::ACQ_RW_MASK;
    end
    case (st_q)
      trs_pkg::ACQ_IDLE: begin
        if (wr_acq && hwdata_i[trs_pkg::ACQ_BIT]) begin
          st_d = trs_pkg::ACQ_START;
          fin_d = 1'b0;
        end
      end
      trs_pkg::ACQ_START: begin
        st_d = trs_pkg::ACQ_WAIT;
      end
      trs_pkg::ACQ_WAIT: begin
        if (temp_done_i) begin
          st_d = trs_pkg::ACQ_IDLE;
          fin_d = 1'b1;
          eval = 1'b1;
        end
      end
      default: begin
        st_d = trs_pkg::ACQ_IDLE;
      end
    endcase
  end

  // read words; next values forwarded so a read right after a write sees it
  always_comb begin
    rail_word = trs_pkg::RAIL_RST;
    rail_word[trs_pkg::RAIL_BOOST_BIT] = rails_s.positive_boost_good;
    rail_word[trs_pkg::RAIL_GH_BIT] = rails_s.gate_high_pump_good;
    rail_word[trs_pkg::RAIL_INV_BIT] = rails_s.inverting_converter_good;
    rail_word[trs_pkg::RAIL_PLDO_BIT] = rails_s.positive_ldo_good;
    rail_word[trs_pkg::RAIL_GL_BIT] = rails_s.gate_low_pump_good;
    rail_word[trs_pkg::RAIL_NLDO_BIT] = rails_s.negative_ldo_good;
    acq_word_d = acq_misc_d;
    acq_word_d[trs_pkg::ACQ_BIT] = (st_d != trs_pkg::ACQ_IDLE);
    acq_word_d[trs_pkg::FIN_BIT] = fin_d;
    rev_word = {trs_pkg::MAJOR_REV, trs_pkg::MINOR_REV, trs_pkg::VERSION};
    hrdata_d = hrdata_q;
    if (ap && !hwrite_i) begin
      hrdata_d = 32'h00000000;
      if (addr_hit(haddr_i, trs_pkg::ADDR_ACQ)) begin
        hrdata_d[7:0] = acq_word_d;
      end
      if (addr_hit(haddr_i, trs_pkg::ADDR_THR)) begin
        hrdata_d[7:0] = thr_d;
      end
      if (addr_hit(haddr_i, trs_pkg::ADDR_RAIL)) begin
        hrdata_d[7:0] = rail_word;
      end
      if (addr_hit(haddr_i, trs_pkg::ADDR_REV)) begin
        hrdata_d[7:0] = rev_word;
      end
    end
  end

  // pin released only with all four gate and ldo rails good
  always_comb begin
    all_good = rails_s.gate_high_pump_good && rails_s.positive_ldo_good
      && rails_s.gate_low_pump_good && rails_s.negative_ldo_good;
    pin_rel_d = all_good;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_pend_q <= 1'b0;
      wa_q <= 10'h000;
      wa_ok_q <= 1'b0;
      hrdata_q <= 32'h00000000;
      thr_q <= trs_pkg::THR_RST;
      acq_misc_q <= trs_pkg::ACQ_RST & trs_pkg::ACQ_RW_MASK;
      fin_q <= trs_pkg::ACQ_RST[trs_pkg::FIN_BIT];
      st_q <= trs_pkg::ACQ_IDLE;
      pin_rel_q <= 1'b0;
    end else begin
      wr_pend_q <= wr_pend_d;
      wa_q <= wa_d;
      wa_ok_q <= wa_ok_d;
      hrdata_q <= hrdata_d;
      thr_q <= thr_d;
      acq_misc_q <= acq_misc_d;
      fin_q <= fin_d;
      st_q <= st_d;
      pin_rel_q <= pin_rel_d;
    end
  end

  assign hrdata_o = hrdata_q;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign temp_start_o = (st_q == trs_pkg::ACQ_START);
  assign all_rails_good_pin_o = 1'b0;
  assign all_rails_good_pin_oe_n_o = pin_rel_q;

  cold_alarm_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    eval |=> alarm_o.cold == ($signed({$past(temp_value_i[7]), $past(temp_value_i)})
      <= $signed({5'h00, $past(thr_q[7:4])}) - 9'sd7))
    else $error("cold alarm does not match threshold");

  hot_alarm_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    eval |=> alarm_o.hot == ($signed({$past(temp_value_i[7]), $past(temp_value_i)})
      >= $signed({5'h00, $past(thr_q[3:0])}) + 9'sd42))
    else $error("hot alarm does not match threshold");

  thr_store_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    wr_thr |=> thr_q == $past(hwdata_i[7:0]))
    else $error("threshold write not stored");

  pin_release_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ##1 all_rails_good_pin_oe_n_o == $past(rails_s.gate_high_pump_good
      && rails_s.positive_ldo_good && rails_s.gate_low_pump_good
      && rails_s.negative_ldo_good))
    else $error("all-good pin does not follow rails");

  rail_read_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (ap && !hwrite_i && addr_hit(haddr_i, trs_pkg::ADDR_RAIL))
      |=> hrdata_o[2] == 1'b0 && hrdata_o[0] == 1'b0
      && hrdata_o[6] == $past(rails_s.gate_high_pump_good))
    else $error("rail status read wrong");

  rev_read_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (ap && !hwrite_i && addr_hit(haddr_i, trs_pkg::ADDR_REV))
      |=> hrdata_o == 32'h00000012)
    else $error("revision read wrong");

  acq_start_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (wr_acq && hwdata_i[7] && st_q == trs_pkg::ACQ_IDLE)
      |=> temp_start_o && !fin_q ##1 !temp_start_o)
    else $error("acquisition start not issued");

  acq_done_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    eval |=> fin_q && st_q == trs_pkg::ACQ_IDLE)
    else $error("acquisition did not self-clear");

  eval_once_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (alarm_o.hot || alarm_o.cold) |-> $past(eval))
    else $error("alarm without a finished acquisition");

  // read-back checks: the data phase shows the rails that the address phase saw and the acquisition state it left
  rail_word_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (ap && !hwrite_i && addr_hit(haddr_i, trs_pkg::ADDR_RAIL))
      |=> hrdata_o == {24'h000000, $past(rails_s.positive_boost_good),
      $past(rails_s.gate_high_pump_good), $past(rails_s.inverting_converter_good),
      $past(rails_s.positive_ldo_good), $past(rails_s.gate_low_pump_good), 1'b0,
      $past(rails_s.negative_ldo_good), 1'b0})
    else $error("rail status word wrong");

  acq_read_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (ap && !hwrite_i && addr_hit(haddr_i, trs_pkg::ADDR_ACQ))
      |=> hrdata_o[7] == (st_q != trs_pkg::ACQ_IDLE) && hrdata_o[5] == fin_q)
    else $error("acquisition status read wrong");

  // thresholds only move on a write to their own word
  thr_hold_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !wr_thr |=> $stable(thr_q))
    else $error("threshold changed without a write");

  // a second start while busy must not restart the converter
  busy_hold_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (st_q == trs_pkg::ACQ_WAIT && !temp_done_i) |=> st_q == trs_pkg::ACQ_WAIT)
    else $error("acquisition left wait without done");

  start_once_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    temp_start_o |=> !temp_start_o && st_q == trs_pkg::ACQ_WAIT)
    else $error("start pulse longer than one cycle");

  stray_done_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (st_q != trs_pkg::ACQ_WAIT) |=> alarm_o == 2'b00)
    else $error("alarm outside an acquisition");

  // cold limit tops out far below the hot one, so never both
  alarm_excl_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !(alarm_o.hot && alarm_o.cold))
    else $error("hot and cold alarm together");

endmodule : trs_regs

// >>> tb/tb_top.sv
// testbench for the thermal limit and rail status register bank.
// assumes trs_regs alone on a 32-bit ahb-lite bus; the bench plays converter and rails.
`timescale 1ns/1ps
module tb_top;
  logic clk, rst_n, hsel, hwrite, hrdy, hresp, pin, pin_o, pin_oe_n, tstart, tdone;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [7:0] tval;
  logic [2:0] hsize;
  logic [1:0] exp_q[$];
  trs_pkg::trs_rails_t rails;
  trs_pkg::trs_alarm_t alarm;
  int checks, bad_count, cyc, seed;

  // open-drain pin with pull-up
  assign pin = pin_oe_n ? 1'b1 : pin_o;

  trs_regs u_dut (
    .core_clk_i(clk),
    .rst_n_i(rst_n),
    .hsel_i(hsel),
    .haddr_i(haddr),
    .htrans_i(htrans),
    .hwrite_i(hwrite),
    .hsize_i(hsize),
    .hwdata_i(hwdata),
    .hready_i(hrdy),
    .hrdata_o(hrdata),
    .hreadyout_o(hrdy),
    .hresp_o(hresp),
    .rails_good_i(rails),
    .all_rails_good_pin_i(pin),
    .all_rails_good_pin_o(pin_o),
    .all_rails_good_pin_oe_n_o(pin_oe_n),
    .temp_start_o(tstart),
    .temp_done_i(tdone),
    .temp_value_i(tval),
    .alarm_o(alarm)
  );

  always #50 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      end_of_test();
    end
  end

  task end_of_test;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // one single transfer: address phase, then data phase
  task bus(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rdat);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= trs_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    rdat = hrdata;
  endtask : bus

  task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task rd(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask : rd

  // one done pulse from the converter, then collect alarm pulses
  task done_pulse(input logic [7:0] t, output logic [1:0] seen);
    @(posedge clk);
    tdone <= 1'b1;
    tval <= t;
    @(posedge clk);
    tdone <= 1'b0;
    tval <= $random(seed);
    seen = 2'h0;
    repeat (3) begin
      @(negedge clk);
      seen = seen | alarm;
    end
  endtask : done_pulse

  task acq(input logic [7:0] thr, input int t);
    logic [1:0] seen;
    int n;
    wr(trs_pkg::ADDR_THR, {24'h0, ~thr});
    wr(trs_pkg::ADDR_ACQ, 32'h80);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (tstart !== 1'b1 && n < 8);
    chk(tstart, 1'b1);
    // thresholds change while busy; the new ones must apply
    wr(trs_pkg::ADDR_THR, {24'h0, thr});
    rd(trs_pkg::ADDR_THR, {24'h0, thr});
    rd(trs_pkg::ADDR_ACQ, 32'h80);
    // a second start while busy is ignored
    wr(trs_pkg::ADDR_ACQ, 32'h80);
    rd(trs_pkg::ADDR_ACQ, 32'h80);
    exp_q.push_back({t >= int'(thr[3:0]) + 42, t <= int'(thr[7:4]) - 7});
    done_pulse(t[7:0], seen);
    chk(seen, exp_q.pop_front());
    rd(trs_pkg::ADDR_ACQ, 32'h20);
  endtask : acq

  initial begin
    logic [31:0] r;
    logic [1:0] seen;
    int c, h, t;
    clk = 0;
    rst_n = 0;
    hsel = 0;
    haddr = 0;
    htrans = 0;
    hwrite = 0;
    hsize = 3'h0;
    hwdata = 0;
    rails = 0;
    tdone = 0;
    tval = 0;
    seed = 32'h5E0B;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(trs_pkg::ADDR_THR, {24'h0, trs_pkg::THR_RST});
    rd(trs_pkg::ADDR_ACQ, {24'h0, trs_pkg::ACQ_RST});
    rd(trs_pkg::ADDR_RAIL, 32'h0);
    chk({pin_oe_n, pin, hresp}, 3'h0);
    r = {24'h0, trs_pkg::MAJOR_REV, trs_pkg::MINOR_REV, trs_pkg::VERSION};
    rd(trs_pkg::ADDR_REV, r);
    wr(trs_pkg::ADDR_REV, 32'hFF);
    rd(trs_pkg::ADDR_REV, r);
    wr(trs_pkg::ADDR_RAIL, 32'hFF);
    rd(trs_pkg::ADDR_RAIL, 32'h0);
    rd(32'h44, 32'h0);
    rd(32'h438, 32'h0);
    wr(trs_pkg::ADDR_ACQ, 32'h5F);
    rd(trs_pkg::ADDR_ACQ, 32'h7F);
    // a done pulse with no acquisition running is ignored
    done_pulse(8'h9C, seen);
    chk(seen, 2'h0);
    rd(trs_pkg::ADDR_ACQ, 32'h7F);
    $display("test reset_and_access done");
    for (int i = 0; i < 16; i++) begin
      r = (i == 0) ? 32'h17 : (i == 1) ? 32'h2F : (i == 2) ? 32'h3F : $random(seed);
      rails <= r[5:0];
      repeat (4) @(posedge clk);
      rd(trs_pkg::ADDR_RAIL, {24'h0, r[5:1], 1'b0, r[0], 1'b0});
      chk({pin_oe_n, pin}, {2{r[4] & r[2] & r[1] & r[0]}});
    end
    $display("test rail_status done");
    for (int i = 0; i < 24; i++) begin
      r = $random(seed);
      c = int'(r[7:4]) - 7;
      h = int'(r[3:0]) + 42;
      t = (i % 4 == 0) ? c : (i % 4 == 1) ? c + 1 : (i % 4 == 2) ? h : h - 1;
      acq(r[7:0], t);
    end
    $display("test thermal_alarms done");
    end_of_test();
  end
endmodule : tb_top
